// File: include/mcj_defines.vh
// constants for the motion conditional jump sequencer
`ifndef MCJ_DEFINES_VH
`define MCJ_DEFINES_VH

// command codes presented by the program fetcher
`define MCJ_CMD_W          4
`define MCJ_CMD_NONE       4'h0
`define MCJ_CMD_BLOCK      4'h1
`define MCJ_CMD_JUMP_UNC   4'h2
`define MCJ_CMD_JUMP_CND   4'h3
`define MCJ_CMD_CONTINUOUS_MOVE      4'h4
`define MCJ_CMD_POSITIONED_MOVE      4'h5
`define MCJ_CMD_DWELL      4'h6
`define MCJ_CMD_WAIT       4'h7
`define MCJ_CMD_PEND       4'h8
`define MCJ_CMD_CALL       4'h9
`define MCJ_CMD_SUBEND     4'hA

// loop update period selection codes and times in nanoseconds
`define MCJ_PER_0P5        2'h0
`define MCJ_PER_1P0        2'h1
`define MCJ_PER_2P0        2'h2
`define MCJ_PER_0P5_NS     500000
`define MCJ_PER_1P0_NS     1000000
`define MCJ_PER_2P0_NS     2000000
`define MCJ_CLK_NS         20
`define MCJ_TICK_0P5       (`MCJ_PER_0P5_NS / `MCJ_CLK_NS)
`define MCJ_TICK_1P0       (`MCJ_PER_1P0_NS / `MCJ_CLK_NS)
`define MCJ_TICK_2P0       (`MCJ_PER_2P0_NS / `MCJ_CLK_NS)

// stop kinds
`define MCJ_STOP_NONE      2'h0
`define MCJ_STOP_JUMP      2'h1
`define MCJ_STOP_NORMAL    2'h2
`define MCJ_STOP_SUB       2'h3

`endif

// File: hdl/mcj_stop_dist.v
// stopping distance estimator: v*v / (2*a), iterative divider
`timescale 1ns/1ps
`default_nettype none
module mcj_stop_dist #(
  parameter VW = 24,
  parameter DW = 48
) (
  input  wire          sys_clk,
  input  wire          rst,
  input  wire          start,
  input  wire [VW-1:0] vel,
  input  wire [VW-1:0] acc,
  output reg           done_q,
  output reg  [DW-1:0] dist_q
);
  reg [DW-1:0] num_q;
  reg [DW-1:0] den_q;
  reg [DW-1:0] rem_q;
  reg [6:0]    cnt_q;
  reg          busy_q;
  wire [DW-1:0] rem_sh;
  wire [DW-1:0] vel_w;
  assign rem_sh = {rem_q[DW-2:0], num_q[DW-1]};
  // zero-extend first so the square keeps all of its bits
  assign vel_w  = {{(DW-VW){1'b0}}, vel};

  // restoring division, one quotient bit per clock
  always @(posedge sys_clk) begin
    if (rst) begin
      num_q  <= {DW{1'b0}};
      den_q  <= {DW{1'b0}};
      rem_q  <= {DW{1'b0}};
      cnt_q  <= 7'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      dist_q <= {DW{1'b0}};
    end else begin
      done_q <= 1'b0;
      if (start) begin
        num_q  <= vel_w * vel_w;
        den_q  <= {{(DW-VW-1){1'b0}}, acc, 1'b0};
        rem_q  <= {DW{1'b0}};
        cnt_q  <= DW[6:0];
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (den_q == {DW{1'b0}}) begin
          // zero acceleration can never stop in time
          dist_q <= {DW{1'b1}};
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          if (rem_sh >= den_q) begin
            rem_q <= rem_sh - den_q;
            num_q <= {num_q[DW-2:0], 1'b1};
          end else begin
            rem_q <= rem_sh;
            num_q <= {num_q[DW-2:0], 1'b0};
          end
          cnt_q <= cnt_q - 7'h01;
          if (cnt_q == 7'h01) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            dist_q <= (rem_sh >= den_q) ? {num_q[DW-2:0], 1'b1}
                                        : {num_q[DW-2:0], 1'b0};
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: hdl/mcj_seq.v
// per-axis conditional jump sequencer
// How it works
// - jump taken at once if selected input already set when testing starts
// - keep destination while testing; jump when the input sets
// - block label, another jump or a call ends testing
// - jump and move in one block: input watched through the whole move
// - testing persists over further moves until the next block label
// - jump from continuous move without stop only if distance beats stopping
// - stopping distance from present velocity and destination acceleration
// - halt on positioned move, reversal, short distance, dwell/wait/end
// - a jump stop uses the current acceleration and mode
// - unconditional jumps never stop the axis
// - testing at a call stops the axis and cancels testing first
// - testing at a subroutine end stops the axis and cancels testing
// - testing starts with the next motion command, after any stop it needs
// - non-stop jump ramps to destination velocity with destination accel
// - s-curve stop: before midpoint level accel, after finish change
// - input checked every clock while testing; final check at a loop update of 0.5, 1.0 or 2.0 ms
// - only the last of several back-to-back conditional jumps is kept
// - new block label after a jump gives one final input evaluation
`timescale 1ns/1ps
`default_nettype none
`include "mcj_defines.vh"
module mcj_seq #(
  parameter NCTL = 12,
  parameter IW   = 4,
  parameter BW   = 8,
  parameter VW   = 24,
  parameter DW   = 48
) (
  input  wire                  sys_clk,
  input  wire                  rst,
  input  wire                  abort,
  input  wire [1:0]            period_sel,
  input  wire [NCTL-1:0]       external_control_input_bit,
  input  wire                  cmd_valid,
  input  wire [`MCJ_CMD_W-1:0] cmd_code,
  input  wire [IW-1:0]         cmd_ctl_idx,
  input  wire [BW-1:0]         cmd_block,
  input  wire                  dest_valid,
  input  wire [`MCJ_CMD_W-1:0] dest_cmd,
  input  wire                  dest_dir_neg,
  input  wire [DW-1:0]         dest_dist,
  input  wire [VW-1:0]         dest_acc,
  input  wire                  cur_dir_neg,
  input  wire [VW-1:0]         cmd_vel,
  input  wire                  scurve,
  input  wire                  past_midpoint,
  input  wire                  axis_at_rest,
  output reg                   cmd_ready_q,
  output reg                   testing_q,
  output reg  [IW-1:0]         sel_idx_q,
  output reg  [BW-1:0]         dest_block_q,
  output reg                   jump_q,
  output reg  [BW-1:0]         jump_block_q,
  output reg  [1:0]            stop_kind_q,
  output reg                   stop_req_q,
  output reg                   use_dest_acc_q,
  output reg                   level_accel_q,
  output reg                   finish_change_q,
  output reg                   sample_tick_q
);
  // states, one-hot
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_ARM  = 6'h02;
  localparam [5:0] S_TEST = 6'h04;
  localparam [5:0] S_CALC = 6'h08;
  localparam [5:0] S_STOP = 6'h10;
  localparam [5:0] S_LAST = 6'h20;

  localparam [31:0] T05 = `MCJ_TICK_0P5;
  localparam [31:0] T10 = `MCJ_TICK_1P0;
  localparam [31:0] T20 = `MCJ_TICK_2P0;

  reg [5:0]        st_q;
  reg [NCTL-1:0]   ctl_m_q;
  reg [NCTL-1:0]   ctl_s_q;
  reg [31:0]       tick_cnt_q;
  reg              armed_q;     // conditional jump seen, no motion yet
  reg              positioned_move_q;     // positioned move is the active motion
  reg              pend_q;      // command held while stop completes
  reg [`MCJ_CMD_W-1:0] pend_cmd_q;
  reg              sd_start_q;
  reg [31:0]       tick_lim;
  wire             sd_done;
  wire [DW-1:0]    sd_dist;
  wire             ctl_hit;
  wire             is_motion;
  wire             is_stopper;

  assign ctl_hit = ctl_s_q[sel_idx_q];
  assign is_motion = cmd_valid &&
    (cmd_code == `MCJ_CMD_CONTINUOUS_MOVE || cmd_code == `MCJ_CMD_POSITIONED_MOVE ||
     cmd_code == `MCJ_CMD_DWELL || cmd_code == `MCJ_CMD_WAIT);
  assign is_stopper = cmd_valid &&
    (cmd_code == `MCJ_CMD_DWELL || cmd_code == `MCJ_CMD_WAIT ||
     cmd_code == `MCJ_CMD_PEND ||
     ((cmd_code == `MCJ_CMD_CONTINUOUS_MOVE || cmd_code == `MCJ_CMD_POSITIONED_MOVE) &&
      cur_dir_neg != dest_dir_neg));

  // stopping distance at the destination acceleration
  mcj_stop_dist #(.VW(VW), .DW(DW)) u_sd (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (sd_start_q),
    .vel     (cmd_vel),
    .acc     (dest_acc),
    .done_q  (sd_done),
    .dist_q  (sd_dist)
  );

  // two-flop synchroniser for the external control inputs
  always @(posedge sys_clk) begin
    if (rst) begin
      ctl_m_q <= {NCTL{1'b0}};
      ctl_s_q <= {NCTL{1'b0}};
    end else begin
      ctl_m_q <= external_control_input_bit;
      ctl_s_q <= ctl_m_q;
    end
  end

  // update period limit from configuration
  always @* begin
    case (period_sel)
      `MCJ_PER_0P5: tick_lim = T05;
      `MCJ_PER_2P0: tick_lim = T20;
      default:      tick_lim = T10;
    endcase
  end

  // loop update enable pulse
  always @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt_q    <= 32'h00000000;
      sample_tick_q <= 1'b0;
    end else if (tick_cnt_q >= tick_lim - 32'h00000001) begin
      tick_cnt_q    <= 32'h00000000;
      sample_tick_q <= 1'b1;
    end else begin
      tick_cnt_q    <= tick_cnt_q + 32'h00000001;
      sample_tick_q <= 1'b0;
    end
  end

  // main sequencer
  always @(posedge sys_clk) begin
    if (rst || abort) begin
      st_q            <= S_IDLE;
      testing_q       <= 1'b0;
      sel_idx_q       <= {IW{1'b0}};
      dest_block_q    <= {BW{1'b0}};
      armed_q         <= 1'b0;
      positioned_move_q         <= 1'b0;
      pend_q          <= 1'b0;
      pend_cmd_q      <= `MCJ_CMD_NONE;
      cmd_ready_q     <= 1'b0;
      jump_q          <= 1'b0;
      jump_block_q    <= {BW{1'b0}};
      stop_kind_q     <= `MCJ_STOP_NONE;
      stop_req_q      <= 1'b0;
      use_dest_acc_q  <= 1'b0;
      level_accel_q   <= 1'b0;
      finish_change_q <= 1'b0;
      sd_start_q      <= 1'b0;
    end else begin
      jump_q      <= 1'b0;
      cmd_ready_q <= 1'b0;
      sd_start_q  <= 1'b0;
      case (st_q)
        S_IDLE, S_ARM: begin
          cmd_ready_q <= cmd_valid && !cmd_ready_q;
          if (cmd_valid && !cmd_ready_q) begin
            if (cmd_code == `MCJ_CMD_JUMP_CND) begin
              sel_idx_q    <= cmd_ctl_idx;
              dest_block_q <= cmd_block;
              armed_q      <= 1'b1;
              st_q         <= S_ARM;
            end else if (cmd_code == `MCJ_CMD_JUMP_UNC) begin
              jump_q       <= 1'b1;
              jump_block_q <= cmd_block;
            end else if (armed_q && is_motion) begin
              // testing begins only once the motion command runs
              positioned_move_q <= (cmd_code == `MCJ_CMD_POSITIONED_MOVE);
              armed_q <= 1'b0;
              if (is_stopper) begin
                stop_kind_q <= `MCJ_STOP_NORMAL;
                stop_req_q  <= 1'b1;
                pend_q      <= 1'b0;
                st_q        <= S_STOP;
              end else begin
                testing_q <= 1'b1;
                st_q      <= S_TEST;
              end
            end else if (armed_q && is_stopper) begin
              stop_kind_q <= `MCJ_STOP_NORMAL;
              stop_req_q  <= 1'b1;
              pend_q      <= 1'b0;
              st_q        <= S_STOP;
            end
          end
        end
        S_TEST: begin
          if (ctl_hit) begin
            // jump trigger, immediate when already set
            testing_q <= 1'b0;
            st_q      <= S_CALC;
            sd_start_q <= 1'b1;
          end else if (cmd_valid && !cmd_ready_q) begin
            cmd_ready_q <= 1'b1;
            case (cmd_code)
              `MCJ_CMD_BLOCK: st_q <= S_LAST;
              `MCJ_CMD_JUMP_CND, `MCJ_CMD_JUMP_UNC: begin
                testing_q <= 1'b0;
                st_q      <= S_IDLE;
                cmd_ready_q <= 1'b0;
              end
              `MCJ_CMD_CALL, `MCJ_CMD_SUBEND: begin
                testing_q   <= 1'b0;
                stop_kind_q <= `MCJ_STOP_SUB;
                stop_req_q  <= 1'b1;
                pend_q      <= 1'b1;
                pend_cmd_q  <= cmd_code;
                cmd_ready_q <= 1'b0;
                st_q        <= S_STOP;
              end
              default: begin
                // further moves in the block keep the test running
                positioned_move_q <= (cmd_code == `MCJ_CMD_POSITIONED_MOVE);
              end
            endcase
          end
        end
        S_LAST: begin
          // one final evaluation at the next loop update
          if (sample_tick_q) begin
            testing_q <= 1'b0;
            if (ctl_hit) begin
              st_q       <= S_CALC;
              sd_start_q <= 1'b1;
            end else begin
              st_q <= S_IDLE;
            end
          end
        end
        S_CALC: begin
          if (sd_done) begin
            jump_block_q <= dest_block_q;
            if (!positioned_move_q && dest_valid &&
                (dest_cmd == `MCJ_CMD_CONTINUOUS_MOVE ||
                 dest_cmd == `MCJ_CMD_POSITIONED_MOVE) &&
                dest_dir_neg == cur_dir_neg &&
                dest_dist > sd_dist) begin
              jump_q         <= 1'b1;
              use_dest_acc_q <= 1'b1;
              st_q           <= S_IDLE;
            end else begin
              stop_kind_q     <= `MCJ_STOP_JUMP;
              stop_req_q      <= 1'b1;
              use_dest_acc_q  <= 1'b0;
              level_accel_q   <= scurve && !past_midpoint;
              finish_change_q <= scurve && past_midpoint;
              pend_q          <= 1'b0;
              st_q            <= S_STOP;
            end
          end
        end
        S_STOP: begin
          if (axis_at_rest) begin
            stop_req_q      <= 1'b0;
            level_accel_q   <= 1'b0;
            finish_change_q <= 1'b0;
            if (stop_kind_q == `MCJ_STOP_JUMP) begin
              jump_q <= 1'b1;
              st_q   <= S_IDLE;
            end else if (stop_kind_q == `MCJ_STOP_NORMAL) begin
              testing_q <= 1'b1;
              st_q      <= S_TEST;
            end else begin
              st_q <= S_IDLE;
            end
            stop_kind_q <= `MCJ_STOP_NONE;
            pend_q      <= 1'b0;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verification/mcj_servo_model.sv
// servo loop stand-in: fixed speed, settles to rest on a stop
`timescale 1ns/1ps
`default_nettype none
module mcj_servo_model #(
  parameter VEL = 24'h000064
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        move_on,
  input  wire logic        slow,
  input  wire logic        stop_req_q,
  output logic      [23:0] cmd_vel,
  output logic             axis_at_rest
);
  logic [7:0] cnt_q;
  // brake for a short or long time, then report rest
  always @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
      axis_at_rest <= 1'b1;
    end else if (stop_req_q || !move_on) begin
      if (cnt_q >= (slow ? 8'h28 : 8'h03)) axis_at_rest <= 1'b1;
      else cnt_q <= cnt_q + 8'h01;
    end else begin
      cnt_q <= 8'h00;
      axis_at_rest <= 1'b0;
    end
  end
  // speed reported to the sequencer
  assign cmd_vel = axis_at_rest ? 24'h000000 : VEL;
endmodule
`default_nettype wire

// File: verification/mcj_seq_checker.sv
// port assertions for the conditional jump sequencer
`timescale 1ns/1ps
`default_nettype none
`include "mcj_defines.vh"
module mcj_seq_checker #(
  parameter NCTL = 12,
  parameter IW   = 4,
  parameter BW   = 8
) (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic                  abort,
  input wire logic [NCTL-1:0]       external_control_input_bit,
  input wire logic                  cmd_valid,
  input wire logic [`MCJ_CMD_W-1:0] cmd_code,
  input wire logic                  axis_at_rest,
  input wire logic                  cmd_ready_q,
  input wire logic                  testing_q,
  input wire logic [IW-1:0]         sel_idx_q,
  input wire logic [BW-1:0]         dest_block_q,
  input wire logic                  jump_q,
  input wire logic [1:0]            stop_kind_q,
  input wire logic                  stop_req_q,
  input wire logic                  level_accel_q,
  input wire logic                  finish_change_q,
  input wire logic                  sample_tick_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // selected input seen high while testing
  sequence s_hit;
    (testing_q && external_control_input_bit[sel_idx_q]) [*2];
  endsequence
  // testing stays on across an edge
  sequence s_held;
    testing_q ##1 testing_q;
  endsequence
  chk_ready_pulse: assert property (cmd_ready_q |=> !cmd_ready_q)
    else $error("ready pulse too long");
  chk_jump_pulse: assert property (jump_q |=> !jump_q)
    else $error("jump pulse too long");
  chk_tick_spacing: assert property (
    sample_tick_q |=> (!sample_tick_q) [*8])
    else $error("loop updates too close");
  chk_abort_clear: assert property (
    abort |=> !testing_q && !jump_q && !stop_req_q)
    else $error("abort left jump state");
  chk_dest_kept: assert property (
    s_held |-> $stable(dest_block_q) && $stable(sel_idx_q))
    else $error("retained jump changed");
  chk_trigger_acts: assert property (
    s_hit |-> ##[0:100] (jump_q || stop_req_q))
    else $error("trigger not acted on");
  chk_stop_holds: assert property (
    stop_req_q && !axis_at_rest |=> stop_req_q)
    else $error("stop dropped before rest");
  chk_call_ends: assert property (
    testing_q && cmd_valid && cmd_code == `MCJ_CMD_CALL
      |-> ##[1:8] !testing_q)
    else $error("call left testing on");
  chk_unc_no_stop: assert property (
    cmd_ready_q && cmd_code == `MCJ_CMD_JUMP_UNC && !stop_req_q
      |=> !stop_req_q)
    else $error("unconditional jump stopped axis");
  chk_scurve_phase: assert property (
    level_accel_q |-> !finish_change_q && stop_kind_q != `MCJ_STOP_NONE)
    else $error("both s-curve phases at once");
endmodule
`default_nettype wire

// File: verification/mcj_seq_tb_top.sv
// self-checking bench for the conditional jump sequencer
`timescale 1ns/1ps
`default_nettype none
`include "mcj_defines.vh"
module mcj_seq_tb_top;
  logic sys_clk = 1'b0, rst = 1'b1, abort = 1'b0, cmd_valid = 1'b0;
  logic dest_valid = 1'b0, dest_dir_neg = 1'b0, scurve = 1'b0, pmid = 1'b0;
  logic move_on = 1'b0, slow = 1'b0, axis_at_rest;
  logic [11:0] ctl = 12'h000;
  logic [3:0] cmd_code = 4'h0, cmd_ctl_idx = 4'h0, dest_cmd = 4'h0;
  logic [7:0] cmd_block = 8'h00, dest_block_q, jump_block_q, gb;
  logic [47:0] dest_dist = 48'h0;
  logic [23:0] cmd_vel;
  logic [3:0] sel_idx_q;
  logic [1:0] stop_kind_q, gk;
  logic cmd_ready_q, testing_q, jump_q, stop_req_q, use_dest_acc_q;
  logic level_accel_q, finish_change_q, sample_tick_q, sj, ss, sd, sl, sf;
  int num_errors = 0, n_compared = 0, cyc = 0;
  // clock at 50 MHz
  always #10 sys_clk = ~sys_clk;
  mcj_seq mcj_seq_i (
    .sys_clk(sys_clk), .rst(rst), .abort(abort), .period_sel(2'h0),
    .external_control_input_bit(ctl), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ctl_idx(cmd_ctl_idx), .cmd_block(cmd_block),
    .dest_valid(dest_valid), .dest_cmd(dest_cmd),
    .dest_dir_neg(dest_dir_neg), .dest_dist(dest_dist),
    .dest_acc(24'h00000A), .cur_dir_neg(1'b0), .cmd_vel(cmd_vel),
    .scurve(scurve), .past_midpoint(pmid), .axis_at_rest(axis_at_rest),
    .cmd_ready_q(cmd_ready_q), .testing_q(testing_q),
    .sel_idx_q(sel_idx_q), .dest_block_q(dest_block_q), .jump_q(jump_q),
    .jump_block_q(jump_block_q), .stop_kind_q(stop_kind_q),
    .stop_req_q(stop_req_q), .use_dest_acc_q(use_dest_acc_q),
    .level_accel_q(level_accel_q), .finish_change_q(finish_change_q),
    .sample_tick_q(sample_tick_q));
  mcj_servo_model mcj_servo_model_i (
    .sys_clk(sys_clk), .rst(rst), .move_on(move_on), .slow(slow),
    .stop_req_q(stop_req_q), .cmd_vel(cmd_vel),
    .axis_at_rest(axis_at_rest));
  task automatic complete_run();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // cut a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic check(input string w, input logic [63:0] s,
                       input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", w, e, s);
    end
  endtask
  task automatic clr();
    {sj, ss, sd, sl, sf, gb, gk} = '0;
  endtask
  // record outputs settled after an edge
  task automatic look();
    if (jump_q === 1'b1) {sj, gb} = {1'b1, jump_block_q};
    if (stop_req_q === 1'b1) {ss, gk} = {1'b1, stop_kind_q};
    if (use_dest_acc_q === 1'b1) sd = 1'b1;
    if (level_accel_q === 1'b1) sl = 1'b1;
    if (finish_change_q === 1'b1) sf = 1'b1;
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
    look();
  endtask
  // offer one command, hold it until consumed, then drop it
  task automatic send(input logic [3:0] c, input logic [3:0] i,
                      input logic [7:0] b);
    int k;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    {cmd_code, cmd_ctl_idx, cmd_block} <= {c, i, b};
    k = 0;
    do begin
      tick();
      k++;
    end while (cmd_ready_q !== 1'b1 && k < 30000);
    check("ready", cmd_ready_q, 1'b1);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    #1;
    look();
  endtask
  // destination facts, axis moving, inputs low
  task automatic aim(input logic [3:0] dc, input logic dn,
                     input logic [47:0] dd, input logic sc);
    @(posedge sys_clk);
    {dest_valid, dest_cmd, dest_dir_neg, dest_dist} <= {1'b1, dc, dn, dd};
    {move_on, scurve, ctl} <= {1'b1, sc, 12'h000};
    repeat (4) tick();
    clr();
  endtask
  // input already set; stop or not by destination kind, direction and distance
  task automatic t_continuous_move(input logic [3:0] dc, input logic dn,
                         input logic [47:0] dd, input logic st);
    aim(dc, dn, dd, 1'b0);
    @(posedge sys_clk);
    ctl[3] <= 1'b1;
    send(`MCJ_CMD_JUMP_CND, 4'h3, 8'h07);
    send(`MCJ_CMD_CONTINUOUS_MOVE, 4'h0, 8'h00);
    repeat (150) tick();
    check("jump block", gb, 8'h07);
    check("stopped", ss, st);
    if (st) check("stop kind", gk, `MCJ_STOP_JUMP);
    else check("dest accel", sd, 1'b1);
  endtask
  // positioned move, trigger later, s-curve before or past midpoint
  task automatic t_positioned_move(input logic pm);
    @(posedge sys_clk);
    pmid <= pm;
    aim(`MCJ_CMD_CONTINUOUS_MOVE, 1'b0, 48'h3E8, 1'b1);
    send(`MCJ_CMD_JUMP_CND, 4'h5, 8'h21);
    send(`MCJ_CMD_POSITIONED_MOVE, 4'h0, 8'h00);
    repeat (20) tick();
    check("testing", testing_q, 1'b1);
    check("retained", {sel_idx_q, dest_block_q}, 12'h521);
    check("early jump", sj, 1'b0);
    @(posedge sys_clk);
    ctl[5] <= 1'b1;
    repeat (150) tick();
    check("stop kind", gk, `MCJ_STOP_JUMP);
    check("level accel", sl, !pm);
    check("finish change", sf, pm);
    check("jump block", gb, 8'h21);
  endtask
  // last of two jumps kept, then a call or subroutine end
  task automatic t_sub(input logic [3:0] c);
    aim(`MCJ_CMD_CONTINUOUS_MOVE, 1'b0, 48'h3E8, 1'b0);
    send(`MCJ_CMD_JUMP_CND, 4'h1, 8'h11);
    send(`MCJ_CMD_JUMP_CND, 4'h2, 8'h12);
    send(`MCJ_CMD_CONTINUOUS_MOVE, 4'h0, 8'h00);
    check("last jump", {sel_idx_q, dest_block_q}, 12'h212);
    clr();
    send(c, 4'h0, 8'h09);
    check("stop kind", gk, `MCJ_STOP_SUB);
    check("testing", testing_q, 1'b0);
  endtask
  task automatic t_unc();
    aim(`MCJ_CMD_CONTINUOUS_MOVE, 1'b0, 48'h3E8, 1'b0);
    send(`MCJ_CMD_CONTINUOUS_MOVE, 4'h0, 8'h00);
    send(`MCJ_CMD_JUMP_UNC, 4'h0, 8'h30);
    send(`MCJ_CMD_CONTINUOUS_MOVE, 4'h0, 8'h00);
    repeat (20) tick();
    check("stopped", ss, 1'b0);
    check("jump block", gb, 8'h30);
  endtask
  // dwell after a jump: normal stop first, then testing over further moves
  task automatic t_dwell();
    aim(`MCJ_CMD_CONTINUOUS_MOVE, 1'b0, 48'h3E8, 1'b0);
    send(`MCJ_CMD_JUMP_CND, 4'h8, 8'h50);
    send(`MCJ_CMD_DWELL, 4'h0, 8'h00);
    check("stop kind", gk, `MCJ_STOP_NORMAL);
    check("testing", testing_q, 1'b0);
    repeat (20) tick();
    check("testing", testing_q, 1'b1);
    send(`MCJ_CMD_CONTINUOUS_MOVE, 4'h0, 8'h00);
    check("testing", testing_q, 1'b1);
    send(`MCJ_CMD_JUMP_CND, 4'h9, 8'h51);
    check("testing", testing_q, 1'b0);
    check("new jump", {sel_idx_q, dest_block_q}, 12'h951);
  endtask
  // block label ends testing, update period, abort clears state
  task automatic t_end();
    int k;
    aim(`MCJ_CMD_CONTINUOUS_MOVE, 1'b0, 48'h3E8, 1'b0);
    send(`MCJ_CMD_JUMP_CND, 4'h6, 8'h44);
    send(`MCJ_CMD_CONTINUOUS_MOVE, 4'h0, 8'h00);
    send(`MCJ_CMD_BLOCK, 4'h0, 8'h02);
    check("testing", testing_q, 1'b1);
    for (int n = 0; n < 2; n++) begin
      k = 0;
      do begin
        tick();
        k++;
      end while (sample_tick_q !== 1'b1 && k < 30000);
    end
    check("update period", k, `MCJ_TICK_0P5);
    check("testing", testing_q, 1'b0);
    check("jumped", sj, 1'b0);
    send(`MCJ_CMD_JUMP_CND, 4'h6, 8'h44);
    send(`MCJ_CMD_CONTINUOUS_MOVE, 4'h0, 8'h00);
    @(posedge sys_clk);
    abort <= 1'b1;
    @(posedge sys_clk);
    abort <= 1'b0;
    tick();
    check("abort", {testing_q, sel_idx_q, dest_block_q}, 13'h0);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    tick();
    check("reset", {testing_q, jump_q, stop_req_q}, 3'h0);
    t_continuous_move(`MCJ_CMD_CONTINUOUS_MOVE, 1'b0, 48'h3E8, 1'b0);
    t_continuous_move(`MCJ_CMD_CONTINUOUS_MOVE, 1'b0, 48'h1F4, 1'b1);
    t_continuous_move(`MCJ_CMD_POSITIONED_MOVE, 1'b0, 48'h3E8, 1'b0);
    slow = 1'b1;
    t_continuous_move(`MCJ_CMD_POSITIONED_MOVE, 1'b1, 48'h3E8, 1'b1);
    slow = 1'b0;
    t_continuous_move(`MCJ_CMD_DWELL, 1'b0, 48'h3E8, 1'b1);
    t_continuous_move(`MCJ_CMD_WAIT, 1'b0, 48'h3E8, 1'b1);
    t_continuous_move(`MCJ_CMD_PEND, 1'b0, 48'h3E8, 1'b1);
    t_positioned_move(1'b0);
    t_positioned_move(1'b1);
    t_sub(`MCJ_CMD_CALL);
    t_sub(`MCJ_CMD_SUBEND);
    t_unc();
    t_dwell();
    t_end();
    complete_run();
  end
endmodule
bind mcj_seq mcj_seq_checker #(.NCTL(NCTL), .IW(IW), .BW(BW))
  mcj_seq_checker_i (.sys_clk(sys_clk), .rst(rst), .abort(abort),
  .external_control_input_bit(external_control_input_bit),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .axis_at_rest(axis_at_rest), .cmd_ready_q(cmd_ready_q),
  .testing_q(testing_q), .sel_idx_q(sel_idx_q),
  .dest_block_q(dest_block_q), .jump_q(jump_q),
  .stop_kind_q(stop_kind_q), .stop_req_q(stop_req_q),
  .level_accel_q(level_accel_q), .finish_change_q(finish_change_q),
  .sample_tick_q(sample_tick_q));
`default_nettype wire
